// ==== common/cib_pkg.sv ====
// Purpose: shared constants and carrier types for the processor/system bus bridge
// Assumes: one clock domain, synchronous active-high reset
// Notes:   address windows, lane widths and pin carriers live here only
`default_nettype none

package cib_pkg;

    // =========================================================
    // widths
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;

    // =========================================================
    // on-board memory windows
    localparam logic [15:0] PROM_BASE = 16'h0000;
    localparam logic [15:0] PROM_LAST = 16'h07FF;
    localparam logic [15:0] RAM_BASE  = 16'h6000;
    localparam logic [15:0] RAM_LAST  = 16'h61FF;
    localparam logic [15:0] CHR_BASE  = 16'h7000;
    localparam logic [15:0] CHR_LAST  = 16'h71FF;

    // chip select fields inside the windows
    localparam int PROM_SEL_LSB = 9;     // four 512-byte proms
    localparam int RAM_SEL_BIT  = 8;     // two 256-byte ram banks

    // character rom drives only the low five lines, the rest pull up
    localparam int          CHR_DRIVEN = 5;
    localparam logic [2:0]  CHR_PULLUP = 3'h7;

    // status word bit that marks a write cycle, captured at sync
    localparam int STS_WRITE_BIT = 1;

    // =========================================================
    // pin carriers: output value plus enable (enable high = driving)
    typedef struct packed {
        logic [BYTE_W-1:0] o;
        logic [BYTE_W-1:0] oe;
    } cib_byte_drv_t;

    typedef struct packed {
        logic [WORD_W-1:0] o;
        logic [WORD_W-1:0] oe;
    } cib_word_drv_t;

    typedef struct packed {
        logic o;
        logic oe;
    } cib_ctl_drv_t;

    // on-board memory enables
    typedef struct packed {
        logic [3:0] prom;
        logic [1:0] ram;
        logic       chr;
        logic       buf_en;
    } cib_mem_sel_t;

endpackage : cib_pkg

`default_nettype wire

// ==== logic/cib_bridge.sv ====
// Purpose: bridge byte processor to 16-bit wired-or system bus, decode on-board memory
// Assumes: processor clock and half-rate clock are both clk_sys (one domain)
// Notes:   every output is a flop, so each pin follows its cause by one cycle; hold-gated pins except the cycle marker trail hold ack by two
`default_nettype none

// What this block does
// - drive processor address onto bus unless held
// - hold acknowledge releases address, read, write drivers
// - hold acknowledge registered before gating drivers
// - write strobe inverted, read strobe direct
// - even byte write latched, driven low lanes
// - odd byte write driven straight to high lanes
// - memory accesses use high lanes only
// - data drivers need no hold, write state
// - receiver enables per register or memory read
// - cycle marker is sync and no hold
// - hold grant is synced hold and select
// - board reset is clear or power clear, registered
// - suspend request is select or hold request, registered
// - bus ready registered into processor ready
// - prom window 0000 to 07FF
// - ram window 6000 to 61FF
// - character rom drives five lines, three read one
// - memory buffers follow write line, on-board only
// - four prom, two ram, one char, one buffer enable
// - bus data and strobes active low, wired-or
module cib_bridge (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // processor side
    input  wire logic [15:0]          cpu_addr,
    input  wire logic [7:0]           cpu_data_in,
    output var  cib_pkg::cib_byte_drv_t cpu_data_drv,
    input  wire logic                 cpu_wr_n,
    input  wire logic                 cpu_read_strobe,
    input  wire logic                 cpu_sync,
    input  wire logic                 cpu_hold_ack,
    output logic                      suspend_req,
    output logic                      cpu_ready,
    // board reset
    input  wire logic                 cpu_clear,
    input  wire logic                 power_on_clear_n,
    output logic                      board_reset,
    output logic                      reset_inverse,
    // system bus
    output var  cib_pkg::cib_word_drv_t sys_bus_addr_drv,
    input  wire logic [15:0]          sys_bus_data_n_in,
    output var  cib_pkg::cib_word_drv_t sys_bus_data_n_drv,
    input  wire logic                 sys_bus_wr_n_in,
    output var  cib_pkg::cib_ctl_drv_t  sys_bus_wr_n_drv,
    output var  cib_pkg::cib_ctl_drv_t  sys_bus_rd_n_drv,
    input  wire logic                 sys_bus_rdy,
    input  wire logic                 bus_hold_req_n,
    input  wire logic                 iface_select_in_n,
    output logic                      bus_cycle_marker_n,
    output logic                      bus_hold_grant_n,
    // on-board memory
    output var  cib_pkg::cib_mem_sel_t  mem_sel,
    output logic                      mem_dir_write,
    input  wire logic [7:0]           mem_data_in,
    output var  cib_pkg::cib_byte_drv_t mem_data_drv
);

    // =========================================================
    // decode helper
    function automatic logic in_window(input logic [15:0] a,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction : in_window

    // =========================================================
    // state
    logic             hold_ack_synced;      // half-rate registered hold ack
    logic             wr_n_prev_q;
    logic             memw_state_q;         // write state caught at sync
    logic [7:0]       low_byte_q;           // byte packing buffer

    // =========================================================
    // address decode
    wire logic        hit_prom = in_window(cpu_addr, cib_pkg::PROM_BASE,
                                           cib_pkg::PROM_LAST);
    wire logic        hit_ram  = in_window(cpu_addr, cib_pkg::RAM_BASE,
                                           cib_pkg::RAM_LAST);
    wire logic        hit_chr  = in_window(cpu_addr, cib_pkg::CHR_BASE,
                                           cib_pkg::CHR_LAST);
    wire logic        on_board = hit_prom | hit_ram | hit_chr;
    wire logic        reg_acc  = ~on_board;
    wire logic        odd_byte = cpu_addr[0];
    wire logic [1:0]  prom_idx = cpu_addr[cib_pkg::PROM_SEL_LSB +: 2];
    wire logic        ram_idx  = cpu_addr[cib_pkg::RAM_SEL_BIT];

    // one enable per chip, each only inside its window
    cib_pkg::cib_mem_sel_t mem_sel_d;
    generate
        for (genvar i = 0; i < 4; i++) begin : g_prom
            assign mem_sel_d.prom[i] = hit_prom && (prom_idx == 2'(i));
        end
        for (genvar j = 0; j < 2; j++) begin : g_ram
            assign mem_sel_d.ram[j] = hit_ram && (ram_idx == 1'(j));
        end
    endgenerate
    assign mem_sel_d.chr    = hit_chr;
    assign mem_sel_d.buf_en = on_board;

    // =========================================================
    // strobes and enables
    wire logic        held        = hold_ack_synced;
    wire logic        wr_lead     = wr_n_prev_q & ~cpu_wr_n;
    wire logic        low_byte_latch_strobe = wr_lead & ~odd_byte & reg_acc;
    wire logic        data_driver_en = ~held & memw_state_q;
    wire logic        rd_now      = cpu_read_strobe & ~held;
    wire logic        high_rx_en  = rd_now;
    wire logic        low_rx_en   = rd_now & reg_acc;
    wire logic        bus_write   = ~sys_bus_wr_n_in;
    wire logic        iface_select = ~iface_select_in_n;
    wire logic        suspend_req_raw = iface_select | ~bus_hold_req_n;
    wire logic        clear_any   = cpu_clear | ~power_on_clear_n;

    // memory read byte; the three undriven char lines read high
    wire logic [7:0]  mem_rd_byte = hit_chr ?
        {cib_pkg::CHR_PULLUP, mem_data_in[cib_pkg::CHR_DRIVEN-1:0]} :
        mem_data_in;
    wire logic        mem_drive_bus = on_board & ~held & ~bus_write;

    // true-level bus word and which lanes this board drives
    wire logic [7:0]  lo_true  = low_byte_q;
    wire logic [7:0]  hi_true  = mem_drive_bus ? mem_rd_byte : cpu_data_in;
    wire logic        lo_drive = data_driver_en & reg_acc;
    wire logic        hi_drive = data_driver_en | mem_drive_bus;

    // open drain: pull low where the true bit is one
    wire logic [15:0] data_oe_d = {hi_true & {8{hi_drive}},
                                   lo_true & {8{lo_drive}}};

    // processor read path, registers unpack by byte address
    wire logic [15:0] bus_true  = ~sys_bus_data_n_in;
    wire logic [7:0]  cpu_rd_d  = (low_rx_en && !odd_byte) ? bus_true[7:0] :
                                                             bus_true[15:8];
    wire logic        cpu_rd_oe = high_rx_en;

    // =========================================================
    // processor side state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_ack_synced <= 1'b0;
            wr_n_prev_q     <= 1'b1;
            memw_state_q    <= 1'b0;
            low_byte_q      <= 8'h00;
        end else begin
            hold_ack_synced <= cpu_hold_ack;
            wr_n_prev_q     <= cpu_wr_n;
            if (cpu_sync) begin
                memw_state_q <= cpu_data_in[cib_pkg::STS_WRITE_BIT];
            end
            if (low_byte_latch_strobe) begin
                low_byte_q <= cpu_data_in;
            end
        end
    end

    // =========================================================
    // system bus pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sys_bus_addr_drv   <= '0;
            sys_bus_data_n_drv <= '0;
            sys_bus_wr_n_drv   <= '0;
            sys_bus_rd_n_drv   <= '0;
            bus_cycle_marker_n <= 1'b1;
            bus_hold_grant_n   <= 1'b1;
        end else begin
            sys_bus_addr_drv.o    <= cpu_addr;
            sys_bus_addr_drv.oe   <= {16{~held}};
            sys_bus_data_n_drv.o  <= 16'h0000;
            sys_bus_data_n_drv.oe <= data_oe_d;
            sys_bus_wr_n_drv.o    <= 1'b0;
            sys_bus_wr_n_drv.oe   <= ~cpu_wr_n & ~held;
            sys_bus_rd_n_drv.o    <= 1'b0;
            sys_bus_rd_n_drv.oe   <= cpu_read_strobe & ~held;
            bus_cycle_marker_n    <= ~(cpu_sync & ~cpu_hold_ack);
            bus_hold_grant_n      <= ~(hold_ack_synced & iface_select);
        end
    end

    // =========================================================
    // processor handshake, reset and memory pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            suspend_req   <= 1'b0;
            cpu_ready     <= 1'b0;
            board_reset   <= 1'b1;
            reset_inverse <= 1'b0;
            cpu_data_drv  <= '0;
            mem_sel       <= '0;
            mem_dir_write <= 1'b0;
            mem_data_drv  <= '0;
        end else begin
            suspend_req     <= suspend_req_raw;
            cpu_ready       <= sys_bus_rdy;
            board_reset     <= clear_any;
            reset_inverse   <= ~clear_any;
            cpu_data_drv.o  <= cpu_rd_d;
            cpu_data_drv.oe <= {8{cpu_rd_oe}};
            mem_sel         <= held ? '0 : mem_sel_d;
            mem_dir_write   <= bus_write;
            mem_data_drv.o  <= bus_true[15:8];
            mem_data_drv.oe <= {8{on_board & ~held & bus_write}};
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_addr_follow: assert property (!cpu_hold_ack ##1 !cpu_hold_ack |=>
        sys_bus_addr_drv.oe == 16'hFFFF && sys_bus_addr_drv.o == $past(cpu_addr))
        else $error("address not forwarded while not held");
    a_hold_release: assert property (cpu_hold_ack ##1 cpu_hold_ack |=>
        sys_bus_addr_drv.oe == 16'h0000 && !sys_bus_wr_n_drv.oe && !sys_bus_rd_n_drv.oe)
        else $error("drivers active during hold");
    a_hold_delay: assert property ($rose(cpu_hold_ack) && $past(!cpu_hold_ack) |=>
        sys_bus_addr_drv.oe == 16'hFFFF ##1 sys_bus_addr_drv.oe == 16'h0000)
        else $error("hold not delayed by one register");
    a_strobe_map: assert property (!cpu_hold_ack ##1 !cpu_hold_ack |=>
        sys_bus_wr_n_drv.oe == !$past(cpu_wr_n) && sys_bus_rd_n_drv.oe == $past(cpu_read_strobe))
        else $error("strobe mapping wrong");
    a_low_latch: assert property (low_byte_latch_strobe |=> low_byte_q == $past(cpu_data_in))
        else $error("low byte not captured");
    a_low_hold: assert property (!low_byte_latch_strobe |=> $stable(low_byte_q))
        else $error("low byte changed without write edge");
    a_drv_gate: assert property (!memw_state_q || hold_ack_synced |=>
        sys_bus_data_n_drv.oe[7:0] == 8'h00) else $error("data drivers enabled illegally");
    a_low_rx: assert property (low_rx_en |-> reg_acc && high_rx_en)
        else $error("low receivers enabled for memory");
    a_mem_lanes: assert property (data_driver_en && on_board |=>
        sys_bus_data_n_drv.oe[7:0] == 8'h00) else $error("memory used low lanes");
    a_cycle_mark: assert property (cpu_sync && !cpu_hold_ack |=> !bus_cycle_marker_n)
        else $error("cycle marker missing");
    a_grant: assert property (hold_ack_synced && !iface_select_in_n |=>
        !bus_hold_grant_n) else $error("hold grant missing");
    a_reset_pair: assert property (board_reset != reset_inverse)
        else $error("reset pair not complementary");
    a_suspend: assert property (suspend_req == $past(suspend_req_raw))
        else $error("suspend request not registered");
    a_ready_reg: assert property (!sys_bus_rdy |=> !cpu_ready)
        else $error("ready not passed");
    a_prom_sel: assert property (hit_prom && !hold_ack_synced |=>
        $onehot(mem_sel.prom) && mem_sel.ram == 2'b00) else $error("prom select wrong");
    a_ram_sel: assert property (hit_ram && !hold_ack_synced |=>
        $onehot(mem_sel.ram) && mem_sel.prom == 4'h0) else $error("ram select wrong");
    a_chr_pull: assert property (hit_chr |-> mem_rd_byte[7:5] == cib_pkg::CHR_PULLUP)
        else $error("char rom upper lines not high");
    a_buf_dir: assert property (mem_data_drv.oe != 8'h00 |-> mem_sel.buf_en && mem_dir_write)
        else $error("memory buffer enabled off board");
    a_unmapped: assert property (!on_board |=> mem_sel == '0)
        else $error("memory enabled for unmapped address");

    // =========================================================
    // lane contents, checked on the pins a cycle after their cause;
    // these catch a wrong source even when the gating is right

    a_high_lanes: assert property (data_driver_en && !mem_drive_bus |=>
        sys_bus_data_n_drv.oe[15:8] == $past(cpu_data_in))
        else $error("high write byte not on high lanes");

    a_low_lanes: assert property (data_driver_en && reg_acc |=>
        sys_bus_data_n_drv.oe[7:0] == $past(low_byte_q))
        else $error("packed low byte not on low lanes");

    a_mem_to_bus: assert property (mem_drive_bus |=>
        sys_bus_data_n_drv.oe[15:8] == $past(mem_rd_byte))
        else $error("memory byte not on high lanes");

    a_data_free: assert property (!data_driver_en && !mem_drive_bus |=>
        sys_bus_data_n_drv.oe == 16'h0000)
        else $error("data lines not released");

    // =========================================================
    // processor read path: low lanes only for even register bytes

    a_read_low: assert property (low_rx_en && !odd_byte |=>
        cpu_data_drv.o == $past(bus_true[7:0]) && cpu_data_drv.oe == 8'hFF)
        else $error("low lanes not returned");

    a_read_high: assert property (high_rx_en && (odd_byte || !reg_acc) |=>
        cpu_data_drv.o == $past(bus_true[15:8]) && cpu_data_drv.oe == 8'hFF)
        else $error("high lanes not returned");

    a_read_off: assert property (!cpu_read_strobe |=>
        cpu_data_drv.oe == 8'h00)
        else $error("receivers on without read strobe");

    a_held_quiet: assert property (hold_ack_synced |=>
        mem_sel == '0 && cpu_data_drv.oe == 8'h00)
        else $error("memory or receivers active during hold");

    // =========================================================
    // handshake and reset pins in their other direction, plus the char rom select

    a_reset_set: assert property (clear_any |=>
        board_reset && !reset_inverse)
        else $error("board reset not raised by clear");

    a_ready_high: assert property (sys_bus_rdy |=> cpu_ready)
        else $error("ready not passed high");

    a_marker_idle: assert property (!cpu_sync |=> bus_cycle_marker_n)
        else $error("cycle marker without sync");

    a_grant_idle: assert property (!hold_ack_synced |=> bus_hold_grant_n)
        else $error("hold grant without hold");

    a_chr_sel: assert property (hit_chr && !hold_ack_synced |=>
        mem_sel.chr && mem_sel.buf_en && mem_sel.prom == 4'h0)
        else $error("char rom select wrong");

    // =========================================================
    // scenario covers

    c_reg_write: cover property (low_byte_latch_strobe ##[1:20] (wr_lead && odd_byte));
    c_reg_read:  cover property (low_rx_en && !odd_byte ##[1:20] (high_rx_en && odd_byte));
    c_hold:      cover property ($rose(hold_ack_synced) ##[1:50] $fell(hold_ack_synced));
    c_wait:      cover property (!cpu_ready [*3] ##1 cpu_ready);
    c_mem_write: cover property (on_board && bus_write && !held);

endmodule : cib_bridge

`default_nettype wire

// ==== tb/cib_bus_model.sv ====
// Purpose: far-side system bus device holding one 16-bit register
// Assumes: the bench resolves the wired-or lines, free lines pull up
// Notes:   slow input holds ready low three cycles at each read start
`default_nettype none
module cib_bus_model #(
    parameter logic [15:0] REG_ADDR = 16'h8010
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // resolved bus lines
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_data_n,
    input  wire logic        bus_wr_n,
    input  wire logic        bus_rd_n,
    input  wire logic        slow,
    // model drives
    output logic [15:0]      data_oe,
    output logic             rdy,
    output logic [15:0]      reg_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_q;
    logic       rd_seen_q;
    wire logic  hit = (bus_addr[15:1] == REG_ADDR[15:1]);
    wire logic  rd_hit = hit & ~bus_rd_n;
    // =========================================================
    // word taken on high byte write, held across both byte reads
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_q <= 16'h0000;
        end else if (hit & bus_addr[0] & ~bus_wr_n) begin
            reg_q <= ~bus_data_n;
        end
    end
    // ready stretch on a new read when slow
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_q <= 2'h0;
            rd_seen_q <= 1'b0;
        end else begin
            rd_seen_q <= rd_hit;
            if (rd_hit & ~rd_seen_q & slow) begin
                wait_q <= 2'h3;
            end else if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
    // pull lines low for ones, release otherwise
    assign rdy = (wait_q == 2'h0);
    assign data_oe = rd_hit ? reg_q : 16'h0000;
endmodule : cib_bus_model
`default_nettype wire

// ==== tb/cib_bridge_tb.sv ====
// Purpose: self-checking bench for the processor/system bus bridge
// Assumes: clk_sys at 50 ns, one bus register in the partner model
// Notes:   clear and suspend first, then decode rows, write, read, memory write and hold cases
`default_nettype none
module cib_bridge_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  sel;
        logic [7:0]  rd;
    } cib_row_t;
    // =========================================================
    // signals
    logic clk_sys = 1'b0, rst = 1'b1, cpu_wr_n = 1'b1, cpu_read_strobe = 1'b0;
    logic cpu_sync = 1'b0, cpu_hold_ack = 1'b0, cpu_clear = 1'b0, slow = 1'b0;
    logic power_on_clear_n = 1'b1, bus_hold_req_n = 1'b1, iface_select_in_n = 1'b1;
    logic [15:0] cpu_addr = 16'h8000, model_oe, model_reg, bus_addr;
    logic [7:0]  cpu_data_in = 8'h00, mem_data_in;
    logic suspend_req, cpu_ready, board_reset, reset_inverse, sys_bus_rdy;
    logic bus_cycle_marker_n, bus_hold_grant_n, mem_dir_write;
    logic [15:0] sys_bus_data_n_in;
    logic sys_bus_wr_n_in;
    cib_pkg::cib_byte_drv_t cpu_data_drv, mem_data_drv;
    cib_pkg::cib_word_drv_t sys_bus_addr_drv, sys_bus_data_n_drv;
    cib_pkg::cib_ctl_drv_t  sys_bus_wr_n_drv, sys_bus_rd_n_drv;
    cib_pkg::cib_mem_sel_t  mem_sel;
    int failures = 0, cmp_count = 0;
    localparam logic [7:0] MEM_BYTE = 8'h3C;
    cib_row_t rows [16] = '{'{16'h0000, 8'h11, 8'h3C}, '{16'h01FF, 8'h11, 8'h3C},
        '{16'h0200, 8'h21, 8'h3C}, '{16'h0400, 8'h41, 8'h3C}, '{16'h07FF, 8'h81, 8'h3C},
        '{16'h0800, 8'h00, 8'h00}, '{16'h5FFF, 8'h00, 8'h00}, '{16'h6000, 8'h05, 8'h3C},
        '{16'h60FF, 8'h05, 8'h3C}, '{16'h6100, 8'h09, 8'h3C}, '{16'h61FF, 8'h09, 8'h3C},
        '{16'h6200, 8'h00, 8'h00}, '{16'h7000, 8'h03, 8'hFC}, '{16'h71FF, 8'h03, 8'hFC},
        '{16'h7200, 8'h00, 8'h00}, '{16'hFFFF, 8'h00, 8'h00}};
    // =========================================================
    // wired-or resolution with pull-ups, on-board memory stand-in
    assign bus_addr = (sys_bus_addr_drv.o & sys_bus_addr_drv.oe) | ~sys_bus_addr_drv.oe;
    assign sys_bus_data_n_in = ~(sys_bus_data_n_drv.oe | model_oe);
    assign sys_bus_wr_n_in = ~sys_bus_wr_n_drv.oe;
    assign mem_data_in = mem_sel.chr ? {3'h7, MEM_BYTE[4:0]}
                       : (mem_sel.buf_en & ~mem_dir_write) ? MEM_BYTE : ~MEM_BYTE;
    always #25 clk_sys = ~clk_sys;
    cib_bridge cib_bridge_inst (.clk_sys, .rst, .cpu_addr, .cpu_data_in, .cpu_data_drv,
        .cpu_wr_n, .cpu_read_strobe, .cpu_sync, .cpu_hold_ack, .suspend_req, .cpu_ready,
        .cpu_clear, .power_on_clear_n, .board_reset, .reset_inverse, .sys_bus_addr_drv,
        .sys_bus_data_n_in, .sys_bus_data_n_drv, .sys_bus_wr_n_in, .sys_bus_wr_n_drv,
        .sys_bus_rd_n_drv, .sys_bus_rdy, .bus_hold_req_n, .iface_select_in_n,
        .bus_cycle_marker_n, .bus_hold_grant_n, .mem_sel, .mem_dir_write, .mem_data_in,
        .mem_data_drv);
    cib_bus_model cib_bus_model_inst (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
        .bus_data_n(sys_bus_data_n_in), .bus_wr_n(sys_bus_wr_n_in),
        .bus_rd_n(~sys_bus_rd_n_drv.oe), .slow(slow), .data_oe(model_oe),
        .rdy(sys_bus_rdy), .reg_q(model_reg));
    // =========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic sync_cycle(input logic [7:0] sts);
        cpu_sync = 1'b1;
        cpu_data_in = sts;
        tick(1);
        check(16'(bus_cycle_marker_n), 16'h0000);
        cpu_sync = 1'b0;
        tick(1);
    endtask : sync_cycle
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_data_in = d;
        cpu_wr_n = 1'b0;
        tick(3);
        cpu_wr_n = 1'b1;
        tick(2);
    endtask : wr_byte
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    // watchdog
    initial begin
        #(3000 * 50);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test;
    end
    // =========================================================
    // main sequence
    initial begin
        tick(12);
        check(sys_bus_addr_drv.oe, 16'h0000);
        check({board_reset, reset_inverse, mem_sel}, 16'h0200);
        rst = 1'b0;
        tick(2);
        cpu_clear = 1'b1;
        tick(2);
        check({board_reset, reset_inverse}, 16'h0002);
        cpu_clear = 1'b0;
        power_on_clear_n = 1'b0;
        tick(2);
        check({board_reset, reset_inverse}, 16'h0002);
        power_on_clear_n = 1'b1;
        tick(2);
        check({board_reset, reset_inverse}, 16'h0001);
        $display("test clear done");
        for (int i = 0; i < 4; i++) begin
            {bus_hold_req_n, iface_select_in_n} = i[1:0];
            tick(2);
            check(16'(suspend_req), 16'(i != 3));
        end
        {bus_hold_req_n, iface_select_in_n} = 2'h3;
        $display("test suspend done");
        cpu_read_strobe = 1'b1;
        foreach (rows[i]) begin
            cpu_addr = rows[i].addr;
            tick(4);
            check(16'(mem_sel), 16'(rows[i].sel));
            check(16'(cpu_data_drv.o), 16'(rows[i].rd));
            check(16'(mem_dir_write), 16'h0000);
        end
        cpu_read_strobe = 1'b0;
        $display("test decode done");
        sync_cycle(8'h02);
        cpu_addr = 16'h8010;
        cpu_wr_n = 1'b0;
        tick(2);
        check(sys_bus_addr_drv.o & sys_bus_addr_drv.oe, 16'h8010);
        check(16'(sys_bus_wr_n_drv.oe), 16'h0001);
        cpu_wr_n = 1'b1;
        tick(1);
        wr_byte(16'h8010, 8'h34);
        wr_byte(16'h8011, 8'h12);
        check(model_reg, 16'h1234);
        sync_cycle(8'h00);
        cpu_addr = 16'h8010;
        cpu_wr_n = 1'b0;
        tick(3);
        check(sys_bus_data_n_drv.oe, 16'h0000);
        cpu_wr_n = 1'b1;
        $display("test write done");
        slow = 1'b1;
        cpu_read_strobe = 1'b1;
        tick(3);
        check(16'(cpu_ready), 16'h0000);
        check(16'(sys_bus_rd_n_drv.oe), 16'h0001);
        tick(5);
        check(16'(cpu_ready), 16'h0001);
        check(16'(cpu_data_drv.o), 16'h0034);
        slow = 1'b0;
        cpu_addr = 16'h8011;
        tick(4);
        check(16'(cpu_data_drv.o), 16'h0012);
        cpu_read_strobe = 1'b0;
        $display("test read done");
        sync_cycle(8'h02);
        wr_byte(16'h0000, 8'h00);
        cpu_addr = 16'h6001;
        cpu_data_in = 8'h5A;
        cpu_wr_n = 1'b0;
        tick(4);
        check({mem_dir_write, 7'h00, mem_data_drv.oe}, 16'h80FF);
        check(16'(mem_data_drv.o), 16'h005A);
        cpu_wr_n = 1'b1;
        $display("test memory write done");
        cpu_read_strobe = 1'b1;
        cpu_addr = 16'h0000;
        iface_select_in_n = 1'b0;
        tick(2);
        cpu_hold_ack = 1'b1;
        tick(1);
        check(sys_bus_addr_drv.oe, 16'hFFFF);
        tick(2);
        check(sys_bus_addr_drv.oe, 16'h0000);
        check({sys_bus_rd_n_drv.oe, sys_bus_wr_n_drv.oe, mem_sel}, 16'h0000);
        check(sys_bus_data_n_drv.oe, 16'h0000);
        check(16'(bus_hold_grant_n), 16'h0000);
        cpu_sync = 1'b1;
        tick(1);
        check(16'(bus_cycle_marker_n), 16'h0001);
        cpu_sync = 1'b0;
        $display("test hold done");
        finish_test;
    end
endmodule : cib_bridge_tb
`default_nettype wire
